// ===== tb/sftp_master_model.sv
// two-wire bus master model: makes the bus clock and pulls the data line low
`timescale 1ns/1ps
`default_nettype none
module sftp_master_model (
    input wire logic i_clk,
    input wire logic i_sda,
    output logic o_scl,
    output logic o_sda_low
);
    // phases of 6, 6, 6 and 7 reference cycles give the 125 ns bus period;
    // every change lands 1 ns after a reference edge, never on the sampling edge
    localparam int Q = 6;
    initial begin
        o_scl = 1'b1;
        o_sda_low = 1'b0;
    end
    task automatic ph(input logic c, input logic d, input int n);
        o_scl = c;
        o_sda_low = d;
        repeat (n) @(posedge i_clk);
        #1;
    endtask : ph
    // data moves only while the clock is low and is taken mid-high
    task automatic xbit(input logic b, output logic s);
        ph(1'b0, o_sda_low, Q);
        ph(1'b0, ~b, Q);
        ph(1'b1, ~b, Q);
        s = i_sda;
        ph(1'b1, ~b, Q + 1);
    endtask : xbit
    // every frame opens here, so this is where the phases line up with the reference clock
    task automatic start();
        @(posedge i_clk);
        #1;
        ph(1'b0, 1'b0, Q);
        ph(1'b1, 1'b0, Q);
        ph(1'b1, 1'b1, Q);
    endtask : start
    // issued only once the master owns the data line again
    task automatic stop();
        ph(1'b0, 1'b1, Q);
        ph(1'b1, 1'b1, Q);
        ph(1'b1, 1'b0, Q);
    endtask : stop
    // msb first, n bits; the ninth clock, with the line released, only follows a full 8-bit byte
    task automatic wbyte(input logic [7:0] v, input int n, output logic ack);
        logic s;
        ack = 1'b1;
        for (int i = 7; i > 7 - n; i--) begin
            xbit(v[i], s);
        end
        if (n == 8) begin
            xbit(1'b1, ack);
        end
    endtask : wbyte
    // acknowledge only while more bytes are wanted
    task automatic rbyte(input logic more, output logic [7:0] v);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            xbit(1'b1, v[i]);
        end
        xbit(~more, s);
    endtask : rbyte
endmodule : sftp_master_model
`default_nettype wire

// ===== tb/sftp_target_tb.sv
// self-checking bench for the two-wire memory target port
`timescale 1ns/1ps
`default_nettype none
module sftp_target_tb;
    import sftp_pkg::*;
    logic clk, rst_n, scl, m_low, sda_oe, sda_o, wp, hs, busy, ack;
    logic [2:0] sel;
    logic [7:0] d;
    logic [13:0] cur, a;
    sftp_mem_req_t mreq;
    logic [7:0] mem [0:16383];
    logic [7:0] emem [0:16383];
    int miscompares, checked;
    // open-drain wire with pull-up; the target only shows its data value while enabled
    wire logic sda = ~m_low & ~(sda_oe & ~sda_o);

    sftp_master_model u_mst (.i_clk(clk), .i_sda(sda), .o_scl(scl), .o_sda_low(m_low));
    sftp_target u_dut (.i_ref_clk(clk), .i_rst_n(rst_n), .i_clk_en(1'b1), .i_scl(scl), .i_sda(sda),
        .o_sda_o(sda_o), .o_sda_oe(sda_oe), .i_device_select_pins(sel), .i_write_protect(wp), .o_mem(mreq),
        .i_mem_rdata(mem[mreq.addr]), .o_hs_mode(hs), .o_busy(busy));

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    // write address is the one shown before the strobe cycle
    always @(posedge clk) begin
        if (mreq.we === 1'b1) begin
            mem[mreq.addr - ADDR_ONE] <= mreq.wdata;
        end
    end

    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string m);
        checked++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask : chk
    task automatic end_of_test();
        if (miscompares == 0 && checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : end_of_test
    task automatic pins(input logic w, input logic [2:0] s);
        @(posedge clk);
        #1;
        wp = w;
        sel = s;
        repeat (8) @(posedge clk);
    endtask : pins
    task automatic addr_set(input logic [13:0] ad);
        u_mst.start();
        u_mst.wbyte({TYPE_CODE, sel, 1'b0}, 8, ack);
        chk({7'h00, ack}, 8'h00, "slave ack");
        d = 8'($urandom);
        u_mst.wbyte({d[7:6], ad[13:8]}, 8, ack);
        chk({7'h00, ack}, 8'h00, "hi ack");
        u_mst.wbyte(ad[7:0], 8, ack);
        chk({7'h00, ack}, 8'h00, "lo ack");
        cur = ad;
    endtask : addr_set
    task automatic wr(input logic [13:0] ad, input int n);
        addr_set(ad);
        for (int k = 0; k < n; k++) begin
            d = 8'($urandom);
            u_mst.wbyte(d, 8, ack);
            chk({7'h00, ack}, {7'h00, wp}, "data ack");
            if (wp === 1'b0) begin
                emem[cur] = d;
                cur = cur + ADDR_ONE;
            end
        end
        u_mst.stop();
    endtask : wr
    task automatic rd(input int n);
        u_mst.start();
        u_mst.wbyte({TYPE_CODE, sel, 1'b1}, 8, ack);
        chk({7'h00, ack}, 8'h00, "read ack");
        for (int k = 0; k < n; k++) begin
            u_mst.rbyte(k < n - 1, d);
            chk(d, emem[cur], "read data");
            cur = cur + ADDR_ONE;
        end
        u_mst.stop();
        repeat (2) @(posedge clk);
        #1;
        chk({7'h00, busy}, 8'h00, "idle after stop");
    endtask : rd

    initial begin
        void'($urandom(32'hfee8));
        for (int i = 0; i < 16384; i++) begin
            mem[i] = 8'($urandom);
            emem[i] = mem[i];
        end
        miscompares = 0;
        checked = 0;
        rst_n = 1'b0;
        wp = 1'b0;
        sel = 3'($urandom);
        repeat (6) @(posedge clk);
        #1;
        rst_n = 1'b1;
        repeat (8) @(posedge clk);
        for (int i = 0; i < 3; i++) begin
            pins(1'b0, 3'($urandom));
            a = 14'($urandom);
            wr(a, 3);
            addr_set(a);
            rd(3);
            rd(2);
        end
        wr(ADDR_TOP, 2);
        addr_set(ADDR_TOP);
        rd(3);
        for (int s = 0; s < 8; s++) begin
            u_mst.start();
            u_mst.wbyte({TYPE_CODE, 3'(s), 1'b0}, 8, ack);
            chk({7'h00, ack}, {7'h00, 3'(s) != sel}, "select");
            u_mst.stop();
        end
        u_mst.start();
        u_mst.wbyte({~TYPE_CODE, sel, 1'b1}, 8, ack);
        chk({7'h00, ack}, 8'h01, "type code");
        u_mst.start();
        u_mst.wbyte({MASTER_CODE, 3'($urandom)}, 8, ack);
        chk({7'h00, ack}, 8'h01, "master code ack");
        chk({7'h00, hs}, 8'h01, "hs on");
        addr_set(14'($urandom));
        chk({7'h00, hs}, 8'h01, "hs held");
        rd(2);
        chk({7'h00, hs}, 8'h00, "hs off");
        // protected write leaves data and the latch alone
        pins(1'b1, sel);
        a = 14'($urandom);
        wr(a, 1);
        pins(1'b0, sel);
        rd(1);
        // a stop inside the byte must not reach the array
        addr_set(a);
        u_mst.wbyte(~emem[a], 7, ack);
        u_mst.stop();
        rd(1);
        end_of_test();
    end
    initial begin
        repeat (100000) @(posedge clk);
        miscompares++;
        end_of_test();
    end
endmodule : sftp_target_tb
`default_nettype wire

// ===== verilog/sftp_pkg.sv
// shared types and constants for the serial memory two-wire target port
package sftp_pkg;
    localparam int unsigned SYNC_W = 6;
    localparam int unsigned IDX_SCL = 0;
    localparam int unsigned IDX_SDA = 1;
    localparam int unsigned IDX_WP = 2;
    localparam int unsigned IDX_SEL = 3;
    localparam int unsigned ADDR_W = 14;
    localparam logic [3:0] TYPE_CODE = 4'ha;
    localparam logic [4:0] MASTER_CODE = 5'h01;
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;
    localparam logic [3:0] CNT_FIRST = 4'h1;
    localparam logic [3:0] CNT_RESET = 4'h0;
    localparam logic [ADDR_W-1:0] ADDR_ONE = 14'h0001;
    localparam logic [ADDR_W-1:0] ADDR_RESET = 14'h0000;
    localparam logic [ADDR_W-1:0] ADDR_TOP = 14'h3fff;
    localparam logic [SYNC_W-1:0] SYNC_RESET = 6'h03;

    typedef enum logic [4:0] {
        ST_IDLE = 5'b00001,
        ST_RECV = 5'b00010,
        ST_SACK = 5'b00100,
        ST_SEND = 5'b01000,
        ST_MACK = 5'b10000
    } sftp_state_t;

    typedef enum logic [1:0] {
        K_SLAVE = 2'h0,
        K_AHI = 2'h1,
        K_ALO = 2'h2,
        K_DATA = 2'h3
    } sftp_kind_t;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [7:0] wdata;
        logic we;
    } sftp_mem_req_t;

    typedef struct packed {
        logic [SYNC_W-1:0] s1;
        logic [SYNC_W-1:0] s2;
        logic [SYNC_W-1:0] s3;
        logic [SYNC_W-1:0] filt;
        logic prev_scl;
        logic prev_sda;
        sftp_state_t st;
        sftp_kind_t kind;
        logic [3:0] cnt;
        logic [7:0] shift;
        logic [5:0] hi;
        logic rw;
        logic ack_ok;
        logic oe;
        logic hs;
        sftp_mem_req_t mem;
    } sftp_regs_t;
endpackage : sftp_pkg

// ===== verilog/sftp_target.sv
// two-wire target front end of a 16k x 8 nonvolatile byte memory
// Behaviour
// - byte address is 14 bits; upper two bits of the address field are ignored.
// - sda rising while scl high is stop; it aborts any operation.
// - sda falling while scl high is start; every command begins with one.
// - start at any point abandons the operation and awaits a slave address.
// - outside start and stop, sda changes only while scl is low.
// - after each 8th bit transmitter releases sda; receiver pulls low to acknowledge.
// - sda high in the acknowledge clock is no-acknowledge; operation ends.
// - master code 00001xxx enters high-speed mode; transfers continue as normal.
// - stop leaves high-speed mode.
// - first byte after start is slave address; bits 7-4 must be 1010.
// - slave address bits 3-1 must match the three select pins.
// - slave address bit 0: one is read, zero is write.
// - write sends two address bytes after the slave address; 14 bits are latched.
// - reads start at the latched address, kept until rewritten or advanced.
// - address latch increments after each data byte, just before its acknowledge.
// - address wraps from 3fff to 0000; transfers have unlimited length.
// - read drives 8 bits, samples acknowledge, continues on ack, ends otherwise.
// - write receives 8 bits then the device drives an acknowledge.
// - every byte travels most significant bit first.
// - a write completes before the next transaction; no ready polling needed.
// - incoming bits sampled on scl rise; outgoing bits change after scl fall.
// - with write protect high, data bytes are not acknowledged nor advance address.
// - array write happens after the 8th data bit, before its acknowledge.
`timescale 1ns/1ps
`default_nettype none
module sftp_target (
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    input wire logic i_clk_en,
    input wire logic i_scl,
    input wire logic i_sda,
    output logic o_sda_o,
    output logic o_sda_oe,
    input wire logic [2:0] i_device_select_pins,
    input wire logic i_write_protect,
    output sftp_pkg::sftp_mem_req_t o_mem,
    input wire logic [7:0] i_mem_rdata,
    output logic o_hs_mode,
    output logic o_busy
);
    import sftp_pkg::*;

    sftp_regs_t q;
    sftp_regs_t d;

    logic scl_now;
    logic sda_now;
    logic scl_rise;
    logic scl_fall;
    logic start_det;
    logic stop_det;
    logic wp_now;
    logic [2:0] sel_now;
    logic byte_done;

    // conditions only ever come from the filtered copies, never the raw pins
    always_comb begin
        scl_now = q.filt[IDX_SCL];
        sda_now = q.filt[IDX_SDA];
        wp_now = q.filt[IDX_WP];
        sel_now = q.filt[IDX_SEL +: 3];
        scl_rise = scl_now & ~q.prev_scl;
        scl_fall = ~scl_now & q.prev_scl;
        stop_det = scl_now & q.prev_scl & sda_now & ~q.prev_sda;
        start_det = scl_now & q.prev_scl & ~sda_now & q.prev_sda;
        byte_done = scl_fall && (q.cnt == BITS_PER_BYTE);
    end

    always_comb begin
        d = q;
        d.mem.we = 1'b0;
        // three stages; a level is taken once stages two and three agree
        d.s1 = {i_device_select_pins, i_write_protect, i_sda, i_scl};
        d.s2 = q.s1;
        d.s3 = q.s2;
        for (int i = 0; i < SYNC_W; i++) begin
            if (q.s2[i] == q.s3[i]) begin
                d.filt[i] = q.s3[i];
            end
        end
        d.prev_scl = scl_now;
        d.prev_sda = sda_now;

        if (stop_det) begin
            // release the line and drop back to standard speed
            d.st = ST_IDLE;
            d.oe = 1'b0;
            d.hs = 1'b0;
            d.cnt = CNT_RESET;
        end else if (start_det) begin
            // a start, repeated or not, always restarts address reception
            d.st = ST_RECV;
            d.kind = K_SLAVE;
            d.oe = 1'b0;
            d.cnt = CNT_RESET;
        end else begin
            case (q.st)
                ST_IDLE: begin
                    d.oe = 1'b0;
                end
                ST_RECV: begin
                    if (scl_rise) begin
                        d.shift = {q.shift[6:0], sda_now};
                        d.cnt = q.cnt + CNT_FIRST;
                    end
                    if (byte_done) begin
                        d.cnt = CNT_RESET;
                        d.st = ST_SACK;
                        d.oe = 1'b1;
                        case (q.kind)
                            K_SLAVE: begin
                                if (q.shift[7:4] == TYPE_CODE && q.shift[3:1] == sel_now) begin
                                    d.rw = q.shift[0];
                                end else begin
                                    // master code is never acknowledged by any target
                                    if (q.shift[7:3] == MASTER_CODE) begin
                                        d.hs = 1'b1;
                                    end
                                    d.st = ST_IDLE;
                                    d.oe = 1'b0;
                                end
                            end
                            K_AHI: begin
                                d.hi = q.shift[5:0];
                            end
                            K_ALO: begin
                                d.mem.addr = {q.hi, q.shift};
                            end
                            default: begin
                                if (wp_now) begin
                                    // protected: no write, no ack, address held
                                    d.st = ST_IDLE;
                                    d.oe = 1'b0;
                                end else begin
                                    // array write lands before the ack clock starts
                                    d.mem.we = 1'b1;
                                    d.mem.wdata = q.shift;
                                    d.mem.addr = q.mem.addr + ADDR_ONE;
                                end
                            end
                        endcase
                    end
                end
                ST_SACK: begin
                    if (scl_fall) begin
                        d.oe = 1'b0;
                        if (q.kind == K_SLAVE && q.rw) begin
                            // first read bit is driven on the same fall that ends the ack
                            d.st = ST_SEND;
                            d.shift = i_mem_rdata;
                            d.oe = ~i_mem_rdata[7];
                            d.cnt = CNT_FIRST;
                        end else begin
                            d.st = ST_RECV;
                            d.cnt = CNT_RESET;
                            case (q.kind)
                                K_SLAVE: d.kind = K_AHI;
                                K_AHI: d.kind = K_ALO;
                                default: d.kind = K_DATA;
                            endcase
                        end
                    end
                end
                ST_SEND: begin
                    if (scl_fall) begin
                        if (q.cnt == BITS_PER_BYTE) begin
                            // release for the master's ack and step the latch first
                            d.st = ST_MACK;
                            d.oe = 1'b0;
                            d.mem.addr = q.mem.addr + ADDR_ONE;
                        end else begin
                            d.shift = {q.shift[6:0], 1'b0};
                            d.oe = ~q.shift[6];
                            d.cnt = q.cnt + CNT_FIRST;
                        end
                    end
                end
                ST_MACK: begin
                    if (scl_rise) begin
                        d.ack_ok = ~sda_now;
                    end
                    if (scl_fall) begin
                        if (q.ack_ok) begin
                            d.st = ST_SEND;
                            d.shift = i_mem_rdata;
                            d.oe = ~i_mem_rdata[7];
                            d.cnt = CNT_FIRST;
                        end else begin
                            // no-ack ends the read so the master can stop or restart
                            d.st = ST_IDLE;
                            d.oe = 1'b0;
                        end
                    end
                end
                default: begin
                    d.st = ST_IDLE;
                    d.oe = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            q.s1 <= SYNC_RESET;
            q.s2 <= SYNC_RESET;
            q.s3 <= SYNC_RESET;
            q.filt <= SYNC_RESET;
            q.prev_scl <= 1'b1;
            q.prev_sda <= 1'b1;
            q.st <= ST_IDLE;
            q.kind <= K_SLAVE;
            q.cnt <= CNT_RESET;
            q.shift <= 8'h00;
            q.hi <= 6'h00;
            q.rw <= 1'b0;
            q.ack_ok <= 1'b0;
            q.oe <= 1'b0;
            q.hs <= 1'b0;
            q.mem.addr <= ADDR_RESET;
            q.mem.wdata <= 8'h00;
            q.mem.we <= 1'b0;
        end else if (i_clk_en) begin
            q <= d;
        end
    end

    // open drain: the data value is always low, only the enable moves
    assign o_sda_o = 1'b0;
    assign o_sda_oe = q.oe;
    assign o_mem = q.mem;
    assign o_hs_mode = q.hs;
    assign o_busy = (q.st != ST_IDLE);

    // checks below assume the clock enable stays high while they are observed
    default clocking cb @(posedge i_ref_clk);
    endclocking
    default disable iff (!i_rst_n || !i_clk_en);

    sequence s_stop_seen;
        stop_det;
    endsequence
    sequence s_released_idle;
        (q.st == ST_IDLE) && !o_sda_oe && !o_hs_mode;
    endsequence

    property p_stop_aborts;
        s_stop_seen |=> s_released_idle;
    endproperty
    a_stop_aborts: assert property (p_stop_aborts) else $error("stop did not abort");

    property p_start_restarts;
        start_det |=> (q.st == ST_RECV) && (q.kind == K_SLAVE) && (q.cnt == CNT_RESET) && !o_sda_oe;
    endproperty
    a_start_restarts: assert property (p_start_restarts) else $error("start did not restart");

    property p_drive_only_scl_low;
        $changed(o_sda_oe) |-> !scl_now;
    endproperty
    a_drive_only_scl_low: assert property (p_drive_only_scl_low) else $error("sda moved while scl high");

    property p_drive_after_fall;
        $changed(o_sda_oe) |-> $past(scl_fall) || $past(stop_det) || $past(start_det);
    endproperty
    a_drive_after_fall: assert property (p_drive_after_fall) else $error("sda changed not after fall");

    property p_write_steps_addr;
        (byte_done && q.st == ST_RECV && q.kind == K_DATA && !wp_now && !stop_det && !start_det)
            |=> o_mem.we && (o_mem.addr == $past(q.mem.addr) + ADDR_ONE) && (o_mem.wdata == $past(q.shift));
    endproperty
    a_write_steps_addr: assert property (p_write_steps_addr) else $error("write or increment missing");

    property p_wrap;
        (q.st == ST_SEND && scl_fall && q.cnt == BITS_PER_BYTE && q.mem.addr == ADDR_TOP && !stop_det && !start_det)
            |=> (o_mem.addr == ADDR_RESET);
    endproperty
    a_wrap: assert property (p_wrap) else $error("address did not wrap");

    property p_protect;
        (byte_done && q.st == ST_RECV && q.kind == K_DATA && wp_now && !stop_det && !start_det)
            |=> !o_mem.we && !o_sda_oe && $stable(o_mem.addr) && (q.st == ST_IDLE);
    endproperty
    a_protect: assert property (p_protect) else $error("protected write accepted");

    property p_addr_match;
        (byte_done && q.st == ST_RECV && q.kind == K_SLAVE && !stop_det && !start_det)
            |=> o_sda_oe == ($past(q.shift[7:4]) == TYPE_CODE && $past(q.shift[3:1]) == $past(sel_now));
    endproperty
    a_addr_match: assert property (p_addr_match) else $error("slave address decode wrong");

    property p_master_code;
        (byte_done && q.st == ST_RECV && q.kind == K_SLAVE && q.shift[7:3] == MASTER_CODE && !stop_det && !start_det)
            |=> o_hs_mode && !o_sda_oe;
    endproperty
    a_master_code: assert property (p_master_code) else $error("master code not taken");

    property p_nack_ends_read;
        (q.st == ST_MACK && !q.ack_ok && scl_fall && !stop_det && !start_det) |=> (q.st == ST_IDLE) && !o_sda_oe;
    endproperty
    a_nack_ends_read: assert property (p_nack_ends_read) else $error("read went on after no-ack");

    property p_ack_held;
        (q.st == ST_SACK) && o_sda_oe && !scl_fall && !stop_det && !start_det |=> o_sda_oe;
    endproperty
    a_ack_held: assert property (p_ack_held) else $error("ack released early");

    sequence s_read_turn;
        (q.st == ST_SACK) && (q.kind == K_SLAVE) && q.rw && scl_fall;
    endsequence

    // the first read bit must come from the byte at the latch, not from a stale shift value
    property p_read_first_bit;
        s_read_turn |=> (q.st == ST_SEND) && (q.shift == $past(i_mem_rdata))
            && (o_sda_oe == !$past(i_mem_rdata[7]));
    endproperty
    a_read_first_bit: assert property (p_read_first_bit) else $error("first read bit wrong");

    property p_send_shift;
        (q.st == ST_SEND) && scl_fall && (q.cnt != BITS_PER_BYTE)
            |=> (o_sda_oe == !$past(q.shift[6])) && (q.cnt == $past(q.cnt) + CNT_FIRST);
    endproperty
    a_send_shift: assert property (p_send_shift) else $error("read bit order wrong");

    property p_recv_ack;
        byte_done && (q.st == ST_RECV) && (q.kind != K_SLAVE) && ((q.kind != K_DATA) || !wp_now)
            |=> o_sda_oe && (q.st == ST_SACK);
    endproperty
    a_recv_ack: assert property (p_recv_ack) else $error("received byte not acknowledged");

    property p_hi_load;
        byte_done && (q.st == ST_RECV) && (q.kind == K_AHI) |=> (q.hi == $past(q.shift[5:0]));
    endproperty
    a_hi_load: assert property (p_hi_load) else $error("upper address bits wrong");

    property p_addr_load;
        byte_done && (q.st == ST_RECV) && (q.kind == K_ALO) |=> (o_mem.addr == {$past(q.hi), $past(q.shift)});
    endproperty
    a_addr_load: assert property (p_addr_load) else $error("address not latched");

    property p_ack_sample;
        (q.st == ST_MACK) && scl_rise |=> (q.ack_ok == !$past(sda_now));
    endproperty
    a_ack_sample: assert property (p_ack_sample) else $error("master ack not taken");

    // a line that differs between stages two and three is still settling and must not move the level
    property p_filter_hold;
        (q.s2[IDX_SCL] != q.s3[IDX_SCL]) |=> $stable(scl_now);
    endproperty
    a_filter_hold: assert property (p_filter_hold) else $error("unsettled clock level taken");
endmodule : sftp_target
`default_nettype wire
